// [hw/spi_cfg_pkg.sv]
// Shared constants and types for the radio serial configuration port
package spi_cfg_pkg;
  // Header byte layout
  localparam int HDR_RW_BIT = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam int ADDR_W = 6;
  // Address map
  localparam logic [5:0] CFG_LAST_ADDR = 6'h2E;
  localparam logic [5:0] STROBE_FIRST = 6'h30;
  localparam logic [5:0] STROBE_LAST = 6'h3D;
  localparam logic [5:0] FIFO_ADDR = 6'h3F;
  localparam int CFG_COUNT = 47;
  localparam logic [7:0] CFG_RESET_VAL = 8'h00;
  // Named strobe codes; all but STB_FLUSH_RX get special handling
  localparam logic [5:0] STB_RESET = 6'h30;
  localparam logic [5:0] STB_GO_IDLE = 6'h31;
  localparam logic [5:0] STB_POWER_DOWN = 6'h32;
  localparam logic [5:0] STB_WAKE_ON_RADIO = 6'h33;
  localparam logic [5:0] STB_OSC_OFF = 6'h34;
  localparam logic [5:0] STB_FLUSH_RX = 6'h35;
  // Status byte layout and main state codes
  localparam int STAT_RDY_BIT = 7;
  localparam int STAT_STATE_LSB = 4;
  localparam logic [3:0] FILL_MAX = 4'hF;
  localparam logic [2:0] ST_IDLE = 3'h0;
  localparam logic [2:0] ST_RX = 3'h1;
  localparam logic [2:0] ST_TX = 3'h2;
  localparam logic [2:0] ST_FAST_TX_READY = 3'h3;
  localparam logic [2:0] ST_CALIBRATE = 3'h4;
  localparam logic [2:0] ST_SETTLING = 3'h5;
  localparam logic [2:0] ST_RX_OVERRUN = 3'h6;
  localparam logic [2:0] ST_TX_STARVED = 3'h7;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_START_NS = 150000;
  localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_NS = 400;
  localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
  // Device byte phase
  typedef enum logic [1:0] {
    PH_HDR = 2'h1,
    PH_DATA = 2'h2
  } phase_e;
  // Host bit engine
  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_WAIT = 6'h02,
    H_LOW = 6'h04,
    H_HIGH = 6'h08,
    H_END = 6'h10,
    H_GAP = 6'h20
  } host_st_e;
endpackage

// [hw/spi_cfg_if.sv]
// Four-wire serial link between host controller and radio port
`timescale 1ns/1ns
`default_nettype none
interface spi_cfg_if;
  logic chip_select_low_n;
  logic ser_clk;
  logic ser_in;
  logic ser_out;
  logic ser_out_oe_n;
  wire ser_out_line;
  // Released line floats high through a pull-up
  assign ser_out_line = ser_out_oe_n ? 1'h1 : ser_out;
  modport dev (input chip_select_low_n, input ser_clk, input ser_in, output ser_out, output ser_out_oe_n);
  modport host (output chip_select_low_n, output ser_clk, output ser_in, input ser_out_line);
endinterface
`default_nettype wire

// [hw/radio_spi_dev.sv]
// Device end: serial configuration slave of the radio
//
// Functional notes
// - Bytes shift most significant bit first.
// - Every transaction opens with one header byte.
// - Chip select rising mid-byte cancels transfer.
// - Host waits for output low before header.
// - Awake device drives output low on select.
// - Status byte shifts out during each header and write data byte.
// - Status bit7 is active-low ready flag.
// - Status bits 6:4 give main state.
// - Bits 3:0 give fill count, saturated 15.
// - Config registers 0x00-0x2E read and write.
// - Writes return status per byte; reads header only.
// - Burst increments address every byte until deselect.
// - 0x30-0x3D: burst status read, else strobe.
// - Host never writes status registers; a burst header there goes as read.
// - Fourteen command strobes start internal sequences.
// - Strobe is header only; read flag picks count.
// - After idle strobe drop strobes until idle.
// - After reset strobe host waits output low.
// - Sleep-type strobes deferred until chip select high.
// - Reset restores every register to default.
// - Host changes frequency settings only while idle.
// - Address 0x3F reaches transmit or receive buffer.
// - Output pin is serial data while selected.
`timescale 1ns/1ns
`default_nettype none
module radio_spi_dev #(
  parameter int OSC_CYC = spi_cfg_pkg::OSC_START_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  spi_cfg_if.dev link,
  input wire logic [2:0] radio_state_in,
  input wire logic [6:0] rx_count_in,
  input wire logic [6:0] tx_free_in,
  input wire logic [7:0] rxf_data_in,
  input wire logic [7:0] status_word_in,
  output logic strobe_out,
  output logic [5:0] strobe_code_out,
  output logic cfg_wr_out,
  output logic [5:0] cfg_addr_out,
  output logic [7:0] cfg_data_out,
  output logic txf_wr_out,
  output logic [7:0] txf_data_out,
  output logic rxf_rd_out,
  output logic [5:0] status_sel_out
);
  localparam int OSC_W = $clog2(OSC_CYC + 1);

  // Pin synchronisers: {select, clock, data}
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 3'h4; // Idle pin levels, so no false clock edge follows reset
      sync2_q <= 3'h4;
      prev_q <= 3'h4;
    end else begin
      sync1_q <= {link.chip_select_low_n, link.ser_clk, link.ser_in};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Edge detection on synchronised pins
  wire cs_n = sync2_q[2];
  wire si = sync2_q[0];
  wire rise_v = sync2_q[1] & ~prev_q[1] & ~cs_n;
  wire fall_v = ~sync2_q[1] & prev_q[1] & ~cs_n;
  wire cs_fall = ~cs_n & prev_q[2];
  wire cs_rise = cs_n & ~prev_q[2];

  spi_cfg_pkg::phase_e phase_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] sh_q;
  logic rw_q;
  logic burst_q;
  logic [5:0] addr_q;
  logic [7:0] data_q;
  logic ld_stat_q;
  logic ld_rx_q;
  logic idle_pend_q;
  logic defer_q;
  logic [5:0] defer_code_q;
  logic asleep_q;
  logic [OSC_W-1:0] osc_cnt_q;
  logic so_q;
  logic oe_n_q;
  logic [7:0] cfg_mem_q [spi_cfg_pkg::CFG_COUNT];

  // Completed byte and header fields
  wire [7:0] byte_in = {sh_q, si};
  wire in_hdr = (phase_q == spi_cfg_pkg::PH_HDR);
  wire byte_done = rise_v & (bit_cnt_q == 3'h7);
  wire b_rw = byte_in[spi_cfg_pkg::HDR_RW_BIT];
  wire b_burst = byte_in[spi_cfg_pkg::HDR_BURST_BIT];
  wire [5:0] b_addr = byte_in[spi_cfg_pkg::ADDR_W-1:0];
  wire b_in_stb = (b_addr >= spi_cfg_pkg::STROBE_FIRST) & (b_addr <= spi_cfg_pkg::STROBE_LAST);

  // Strobe filtering and deferral
  wire stb_hit = byte_done & in_hdr & b_in_stb & ~b_burst;
  wire stb_take = stb_hit & ~idle_pend_q;
  wire stb_sleepy = (b_addr == spi_cfg_pkg::STB_POWER_DOWN) | (b_addr == spi_cfg_pkg::STB_WAKE_ON_RADIO) |
                    (b_addr == spi_cfg_pkg::STB_OSC_OFF);
  wire stb_now = stb_take & ~stb_sleepy;
  wire stb_later = stb_take & stb_sleepy;
  wire defer_fire = cs_rise & defer_q;
  wire stb_reset = stb_now & (b_addr == spi_cfg_pkg::STB_RESET);
  wire stb_idle = stb_now & (b_addr == spi_cfg_pkg::STB_GO_IDLE);
  wire defer_sleeps = (defer_code_q == spi_cfg_pkg::STB_POWER_DOWN) | (defer_code_q == spi_cfg_pkg::STB_OSC_OFF);

  // Data-phase writes and read preparation
  wire wr_byte = byte_done & ~in_hdr & ~rw_q;
  wire cfg_wr_w = wr_byte & (addr_q <= spi_cfg_pkg::CFG_LAST_ADDR);
  wire txf_wr_w = wr_byte & (addr_q == spi_cfg_pkg::FIFO_ADDR);
  wire [5:0] addr_nx = 6'(addr_q + 6'h01);
  wire rd_go = byte_done & (in_hdr ? (~stb_hit & b_rw) : (rw_q & burst_q));
  wire [5:0] rd_addr = in_hdr ? b_addr : addr_nx;
  wire rd_burst = in_hdr ? b_burst : burst_q;
  wire rd_cfg = rd_addr <= spi_cfg_pkg::CFG_LAST_ADDR;
  wire rd_stat = rd_burst & (rd_addr >= spi_cfg_pkg::STROBE_FIRST) &
                 (rd_addr <= spi_cfg_pkg::STROBE_LAST);
  wire rd_fifo = rd_addr == spi_cfg_pkg::FIFO_ADDR;

  // Status byte, with the count picked by the read flag
  wire not_ready = asleep_q | (osc_cnt_q != '0);
  wire [6:0] fill_raw = rw_q ? rx_count_in : tx_free_in;
  wire [3:0] fill = (|fill_raw[6:4]) ? spi_cfg_pkg::FILL_MAX : fill_raw[3:0];
  wire [7:0] status_byte = {not_ready, radio_state_in, fill};
  // Reads return data after the header, writes return status every byte
  wire [7:0] out_byte = (~in_hdr & rw_q) ? data_q : status_byte;
  wire hdr_wait = in_hdr & (bit_cnt_q == 3'h0);

  // Byte framing, address counter and read data
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= spi_cfg_pkg::PH_HDR;
      bit_cnt_q <= 3'h0;
      sh_q <= 7'h00;
      rw_q <= 1'h0;
      burst_q <= 1'h0;
      addr_q <= 6'h00;
      data_q <= 8'h00;
      ld_stat_q <= 1'h0;
      ld_rx_q <= 1'h0;
    end else if (cs_n) begin
      phase_q <= spi_cfg_pkg::PH_HDR;
      bit_cnt_q <= 3'h0;
      ld_stat_q <= 1'h0;
      ld_rx_q <= 1'h0;
    end else begin
      ld_stat_q <= rd_go & rd_stat;
      ld_rx_q <= rd_go & rd_fifo;
      if (ld_stat_q) begin
        data_q <= status_word_in;
      end else if (ld_rx_q) begin
        data_q <= rxf_data_in;
      end else if (rd_go) begin
        data_q <= rd_cfg ? cfg_mem_q[rd_addr] : 8'h00;
      end
      if (rise_v) begin
        sh_q <= byte_in[6:0];
        bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
        if (hdr_wait) begin
          rw_q <= si;
        end
      end
      if (byte_done) begin
        case (phase_q)
          spi_cfg_pkg::PH_HDR: begin
            if (!stb_hit) begin
              phase_q <= spi_cfg_pkg::PH_DATA;
              burst_q <= b_burst;
              addr_q <= b_addr;
            end
          end
          spi_cfg_pkg::PH_DATA: begin
            if (burst_q) begin
              addr_q <= addr_nx;
            end else begin
              phase_q <= spi_cfg_pkg::PH_HDR;
            end
          end
          default: phase_q <= spi_cfg_pkg::PH_HDR;
        endcase
      end
    end
  end

  // Configuration store; a reset strobe restores defaults
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < spi_cfg_pkg::CFG_COUNT; i++) begin
        cfg_mem_q[i] <= spi_cfg_pkg::CFG_RESET_VAL;
      end
    end else if (stb_reset) begin
      for (int i = 0; i < spi_cfg_pkg::CFG_COUNT; i++) begin
        cfg_mem_q[i] <= spi_cfg_pkg::CFG_RESET_VAL;
      end
    end else if (cfg_wr_w) begin
      cfg_mem_q[addr_q] <= byte_in;
    end
  end

  // Strobe issue, idle lockout, sleep and oscillator start-up
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_out <= 1'h0;
      strobe_code_out <= 6'h00;
      idle_pend_q <= 1'h0;
      defer_q <= 1'h0;
      defer_code_q <= 6'h00;
      asleep_q <= 1'h0;
      osc_cnt_q <= OSC_W'(OSC_CYC);
    end else begin
      strobe_out <= stb_now | defer_fire;
      if (stb_now) begin
        strobe_code_out <= b_addr;
      end else if (defer_fire) begin
        strobe_code_out <= defer_code_q;
      end
      // Set wins over the clear when both land together
      if (stb_idle) begin
        idle_pend_q <= 1'h1;
      end else if (radio_state_in == spi_cfg_pkg::ST_IDLE) begin
        idle_pend_q <= 1'h0;
      end
      if (stb_later) begin
        defer_q <= 1'h1;
        defer_code_q <= b_addr;
      end else if (defer_fire) begin
        defer_q <= 1'h0;
      end
      // A sleeping core wakes on select and must restart its oscillator
      if (defer_fire && defer_sleeps) begin
        asleep_q <= 1'h1;
      end else if (cs_fall && asleep_q) begin
        asleep_q <= 1'h0;
        osc_cnt_q <= OSC_W'(OSC_CYC);
      end else if (stb_reset) begin
        osc_cnt_q <= OSC_W'(OSC_CYC);
      end else if (osc_cnt_q != '0) begin
        osc_cnt_q <= OSC_W'(osc_cnt_q - 1'h1);
      end
    end
  end

  // Serial output: ready level while awaiting a header, else shift on falling clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      so_q <= 1'h1;
      oe_n_q <= 1'h1;
    end else begin
      oe_n_q <= cs_n;
      if (cs_n) begin
        so_q <= 1'h1;
      end else if (hdr_wait) begin
        so_q <= not_ready;
      end else if (fall_v) begin
        so_q <= out_byte[3'h7 - bit_cnt_q];
      end
    end
  end
  assign link.ser_out = so_q;
  assign link.ser_out_oe_n = oe_n_q;

  // User-side write and read notifications
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_wr_out <= 1'h0;
      cfg_addr_out <= 6'h00;
      cfg_data_out <= 8'h00;
      txf_wr_out <= 1'h0;
      txf_data_out <= 8'h00;
      rxf_rd_out <= 1'h0;
      status_sel_out <= 6'h00;
    end else begin
      cfg_wr_out <= cfg_wr_w;
      txf_wr_out <= txf_wr_w;
      rxf_rd_out <= rd_go & rd_fifo;
      if (cfg_wr_w) begin
        cfg_addr_out <= addr_q;
        cfg_data_out <= byte_in;
      end
      if (txf_wr_w) begin
        txf_data_out <= byte_in;
      end
      if (rd_go && rd_stat) begin
        status_sel_out <= rd_addr;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/radio_spi_host.sv]
// Host end: serial bus master driving the radio configuration port
`timescale 1ns/1ns
`default_nettype none
module radio_spi_host #(
  parameter int HALF_CYC = spi_cfg_pkg::SCLK_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  spi_cfg_if.host link,
  input wire logic req_valid_in,
  input wire logic [7:0] req_byte_in,
  input wire logic req_hdr_in,
  input wire logic req_last_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_byte_out,
  output logic rsp_idle_out
);
  // Serial output line synchroniser
  logic so1_q;
  logic so2_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      so1_q <= 1'h1;
      so2_q <= 1'h1;
    end else begin
      so1_q <= link.ser_out_line;
      so2_q <= so1_q;
    end
  end

  spi_cfg_pkg::host_st_e st_q;
  logic [7:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic hdr_q;
  logic last_q;
  logic cs_q;
  logic sclk_q;
  logic si_q;

  // A header to a status register is always sent as a read
  wire req_stat = req_hdr_in & (req_byte_in[5:0] >= spi_cfg_pkg::STROBE_FIRST) &
                  (req_byte_in[5:0] <= spi_cfg_pkg::STROBE_LAST) & req_byte_in[spi_cfg_pkg::HDR_BURST_BIT];
  wire [7:0] req_fixed = req_stat ? (req_byte_in | 8'h80) : req_byte_in;
  wire cnt_done = cnt_q == 8'h00;
  wire [7:0] rx_nx = {rx_q[6:0], so2_q};
  wire [7:0] half = 8'(HALF_CYC - 1);

  // Bit engine: data set while clock low, sampled at end of clock high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= spi_cfg_pkg::H_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 3'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      hdr_q <= 1'h0;
      last_q <= 1'h0;
      cs_q <= 1'h1;
      sclk_q <= 1'h0;
      si_q <= 1'h0;
      req_ready_out <= 1'h1;
      rsp_valid_out <= 1'h0;
      rsp_byte_out <= 8'h00;
      rsp_idle_out <= 1'h0;
    end else begin
      rsp_valid_out <= 1'h0;
      cnt_q <= cnt_done ? 8'h00 : 8'(cnt_q - 8'h01);
      case (st_q)
        spi_cfg_pkg::H_IDLE: begin
          if (req_valid_in && req_ready_out) begin
            req_ready_out <= 1'h0;
            tx_q <= req_fixed;
            hdr_q <= req_hdr_in;
            last_q <= req_last_in;
            cs_q <= 1'h0;
            bit_q <= 3'h0;
            cnt_q <= half;
            st_q <= spi_cfg_pkg::H_WAIT;
          end
        end
        spi_cfg_pkg::H_WAIT: begin
          // Header waits for the ready level; the dwell lets a level just changed by the device reach so2_q
          if (cnt_done && (!hdr_q || !so2_q)) begin
            si_q <= tx_q[7];
            cnt_q <= half;
            st_q <= spi_cfg_pkg::H_LOW;
          end
        end
        spi_cfg_pkg::H_LOW: begin
          if (cnt_done) begin
            sclk_q <= 1'h1;
            cnt_q <= half;
            st_q <= spi_cfg_pkg::H_HIGH;
          end
        end
        spi_cfg_pkg::H_HIGH: begin
          if (cnt_done) begin
            sclk_q <= 1'h0;
            rx_q <= rx_nx;
            bit_q <= 3'(bit_q + 3'h1);
            tx_q <= {tx_q[6:0], 1'h0};
            cnt_q <= half;
            if (bit_q == 3'h7) begin
              rsp_valid_out <= 1'h1;
              rsp_byte_out <= rx_nx;
              if (hdr_q) begin
                rsp_idle_out <= rx_nx[6:4] == spi_cfg_pkg::ST_IDLE;
              end
              if (last_q) begin
                st_q <= spi_cfg_pkg::H_END;
              end else begin
                req_ready_out <= 1'h1;
                st_q <= spi_cfg_pkg::H_IDLE;
              end
            end else begin
              si_q <= tx_q[6];
              st_q <= spi_cfg_pkg::H_LOW;
            end
          end
        end
        spi_cfg_pkg::H_END: begin
          if (cnt_done) begin
            cs_q <= 1'h1;
            cnt_q <= half;
            st_q <= spi_cfg_pkg::H_GAP;
          end
        end
        spi_cfg_pkg::H_GAP: begin
          // Keep select high long enough for the device to see it
          if (cnt_done) begin
            req_ready_out <= 1'h1;
            st_q <= spi_cfg_pkg::H_IDLE;
          end
        end
        default: st_q <= spi_cfg_pkg::H_IDLE;
      endcase
    end
  end
  assign link.chip_select_low_n = cs_q;
  assign link.ser_clk = sclk_q;
  assign link.ser_in = si_q;
endmodule
`default_nettype wire

// [tb/radio_spi_config_port_asserts.sv]
// Link-level checks on the serial wires between host and radio port
`timescale 1ns/1ns
`default_nettype none
module radio_spi_config_port_asserts #(
  parameter int OSC_CYC = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic chip_select_low_n,
  input wire logic ser_clk,
  input wire logic ser_in,
  input wire logic ser_out,
  input wire logic ser_out_oe_n,
  input wire logic ser_out_line
);
  logic [15:0] boot_q;
  logic hdr_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Cycles since reset release; saturates so it never wraps into the busy window
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_q <= 16'h0000;
    end else if (boot_q != 16'hFFFF) begin
      boot_q <= boot_q + 16'h0001;
    end
  end
  // Frame opened, first serial clock not seen yet
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hdr_q <= 1'b0;
    end else if ($fell(chip_select_low_n)) begin
      hdr_q <= 1'b1;
    end else if (ser_clk || chip_select_low_n) begin
      hdr_q <= 1'b0;
    end
  end
  // Clock high phase is exactly four system cycles
  sequence clk_high_s;
    ser_clk [*4] ##1 !ser_clk;
  endsequence
  // Output enable follows select within the synchroniser delay
  sequence oe_on_s;
    ##[1:4] !ser_out_oe_n;
  endsequence
  sequence oe_off_s;
    ##[1:4] ser_out_oe_n;
  endsequence
  drive_on_select_a: assert property ($fell(chip_select_low_n) |-> oe_on_s)
    else $error("Output not driven after select");
  release_on_deselect_a: assert property ($rose(chip_select_low_n) |-> oe_off_s)
    else $error("Output still driven after deselect");
  host_waits_ready_a: assert property (hdr_q && $rose(ser_clk) |-> !$past(ser_out_line))
    else $error("First clock before output went low");
  ready_before_clock_a: assert property (hdr_q && $rose(ser_clk) |-> !ser_out && !ser_out_oe_n)
    else $error("Ready flag not low at first clock");
  boot_not_ready_a: assert property (boot_q < 16'(OSC_CYC) |-> ser_out)
    else $error("Ready flag low during oscillator start");
  data_in_hold_a: assert property (ser_clk && $past(ser_clk) |-> $stable(ser_in))
    else $error("Input data moved while clock high");
  status_out_hold_a: assert property ($rose(ser_clk) && !chip_select_low_n |-> $stable(ser_out) [*2])
    else $error("Output data moved after rising clock");
  clock_pulse_a: assert property ($rose(ser_clk) |-> clk_high_s)
    else $error("Serial clock high phase wrong length");
  clock_idle_a: assert property (chip_select_low_n |-> !ser_clk)
    else $error("Serial clock active while deselected");
endmodule
`default_nettype wire

// [tb/radio_spi_config_port_bench.sv]
// Self-checking bench joining host and device ends of the radio serial port
`timescale 1ns/1ns
`default_nettype none
module radio_spi_config_port_bench;
  localparam int OSC = 8;
  logic clk, rst_n, abort_n, req_valid, req_hdr, req_last;
  logic [7:0] req_byte, rxf_data;
  logic [2:0] radio_state;
  logic [6:0] rx_count, tx_free;
  logic strobe, cfg_wr, txf_wr, rxf_rd, req_ready, rsp_valid, rsp_idle;
  logic [5:0] strobe_code, cfg_addr, status_sel;
  logic [7:0] cfg_data, txf_data, rsp_byte;
  wire logic [7:0] status_word;
  wire logic host_rst_n;
  logic [15:0] wq[$], sq[$], tq[$];
  logic [7:0] dq[3];
  int rd_n, fails, total_checks;
  // Host alone can be reset to pull select high in mid-byte
  assign host_rst_n = rst_n & abort_n;
  // Status register value derived from the selection, as a real map would
  assign status_word = {2'b10, status_sel};
  spi_cfg_if link_if ();
  radio_spi_dev #(.OSC_CYC(OSC)) radio_spi_dev_inst (.clk_in(clk), .rst_n_in(rst_n), .link(link_if),
    .radio_state_in(radio_state), .rx_count_in(rx_count), .tx_free_in(tx_free), .rxf_data_in(rxf_data),
    .status_word_in(status_word), .strobe_out(strobe), .strobe_code_out(strobe_code), .cfg_wr_out(cfg_wr),
    .cfg_addr_out(cfg_addr), .cfg_data_out(cfg_data), .txf_wr_out(txf_wr), .txf_data_out(txf_data),
    .rxf_rd_out(rxf_rd), .status_sel_out(status_sel));
  radio_spi_host radio_spi_host_inst (.clk_in(clk), .rst_n_in(host_rst_n), .link(link_if),
    .req_valid_in(req_valid), .req_byte_in(req_byte), .req_hdr_in(req_hdr), .req_last_in(req_last),
    .req_ready_out(req_ready), .rsp_valid_out(rsp_valid), .rsp_byte_out(rsp_byte), .rsp_idle_out(rsp_idle));
  radio_spi_config_port_asserts #(.OSC_CYC(OSC)) radio_spi_config_port_asserts_inst (.clk_in(clk),
    .rst_n_in(rst_n), .chip_select_low_n(link_if.chip_select_low_n), .ser_clk(link_if.ser_clk),
    .ser_in(link_if.ser_in), .ser_out(link_if.ser_out), .ser_out_oe_n(link_if.ser_out_oe_n),
    .ser_out_line(link_if.ser_out_line));
  // Record every user-side event; select level shows whether a strobe was deferred
  always @(posedge clk) begin
    if (cfg_wr === 1'b1) wq.push_back({2'b00, cfg_addr, cfg_data});
    if (strobe === 1'b1) sq.push_back({9'h000, link_if.chip_select_low_n, strobe_code});
    if (txf_wr === 1'b1) tq.push_back({8'h00, txf_data});
    if (rxf_rd === 1'b1) rd_n++;
  end
  // Expected status byte: ready, state, saturated fill of the chosen buffer
  function automatic logic [7:0] stat(input logic rd);
    logic [6:0] c;
    c = rd ? rx_count : tx_free;
    return {1'b0, radio_state, (c > 7'h0F) ? 4'hF : c[3:0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Present one byte once the host is ready; held until the taking edge has passed
  task automatic send(input logic [7:0] b, input logic h, input logic l);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) fails++;
    req_byte = b;
    req_hdr = h;
    req_last = l;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic acc(input logic [7:0] b, input logic h, input logic l, input logic [7:0] e);
    int n;
    n = 0;
    send(b, h, l);
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) fails++;
    chk({8'h00, rsp_byte}, {8'h00, e});
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    abort_n = 1'b1;
    req_valid = 1'b0;
    req_byte = 8'h00;
    req_hdr = 1'b0;
    req_last = 1'b0;
    radio_state = spi_cfg_pkg::ST_IDLE;
    rx_count = 7'h03;
    tx_free = 7'h28;
    rxf_data = 8'h9E;
    dq = '{8'h32, 8'h33, 8'h34};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    // Burst write from 0x05 right after reset; host must wait for ready
    acc(8'h45, 1'b1, 1'b0, stat(1'b0));
    acc(8'hA5, 1'b0, 1'b0, stat(1'b0));
    acc(8'h5A, 1'b0, 1'b1, stat(1'b0));
    repeat (8) @(negedge clk);
    chk(16'(wq.size()), 16'h0002);
    chk(wq.pop_front(), 16'h05A5);
    chk(wq.pop_front(), 16'h065A);
    // Burst read across untouched defaults and the written pair
    acc(8'hC4, 1'b1, 1'b0, stat(1'b1));
    acc(8'h00, 1'b0, 1'b0, 8'h00);
    acc(8'h00, 1'b0, 1'b0, 8'hA5);
    acc(8'h00, 1'b0, 1'b0, 8'h5A);
    acc(8'h00, 1'b0, 1'b1, 8'h00);
    // Last configuration address, single write then single read
    acc(8'h2E, 1'b1, 1'b0, stat(1'b0));
    acc(8'hC3, 1'b0, 1'b1, stat(1'b0));
    acc(8'hAE, 1'b1, 1'b0, stat(1'b1));
    acc(8'h00, 1'b0, 1'b1, 8'hC3);
    chk(wq.pop_front(), 16'h2EC3);
    // Select rises in mid data byte: no write may land
    acc(8'h09, 1'b1, 1'b0, stat(1'b0));
    send(8'h77, 1'b0, 1'b1);
    repeat (20) @(negedge clk);
    @(negedge link_if.ser_clk);
    @(negedge clk);
    abort_n = 1'b0;
    repeat (2) @(negedge clk);
    abort_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(16'(wq.size()), 16'h0000);
    acc(8'h89, 1'b1, 1'b0, stat(1'b1));
    acc(8'h00, 1'b0, 1'b1, 8'h00);
    // Every main state code and a spread of fill counts, each with a pass-through strobe
    for (int i = 0; i < 8; i++) begin
      radio_state = 3'(i);
      tx_free = 7'(i * 3);
      acc(8'h35 + 8'(i), 1'b1, 1'b1, stat(1'b0));
      repeat (4) @(negedge clk);
      chk(sq.pop_front(), 16'h0035 + 16'(i));
    end
    radio_state = spi_cfg_pkg::ST_IDLE;
    tx_free = 7'h28;
    acc(8'hBD, 1'b1, 1'b1, stat(1'b1));
    // Idle strobe locks out further strobes until idle is reported
    radio_state = spi_cfg_pkg::ST_RX;
    acc(8'h31, 1'b1, 1'b1, stat(1'b0));
    chk({15'h0000, rsp_idle}, 16'h0000);
    acc(8'h36, 1'b1, 1'b1, stat(1'b0));
    radio_state = spi_cfg_pkg::ST_IDLE;
    repeat (4) @(negedge clk);
    acc(8'h37, 1'b1, 1'b1, stat(1'b0));
    chk({15'h0000, rsp_idle}, 16'h0001);
    repeat (4) @(negedge clk);
    chk(16'(sq.size()), 16'h0003);
    chk(sq[0], 16'h003D);
    chk(sq[1], 16'h0031);
    chk(sq[2], 16'h0037);
    sq.delete();
    // Status register through burst header, then buffer ports
    acc(8'hF0, 1'b1, 1'b0, stat(1'b1));
    acc(8'h00, 1'b0, 1'b1, 8'hB0);
    acc(8'h3F, 1'b1, 1'b0, stat(1'b0));
    acc(8'h3C, 1'b0, 1'b1, stat(1'b0));
    acc(8'hBF, 1'b1, 1'b0, stat(1'b1));
    acc(8'h00, 1'b0, 1'b1, 8'h9E);
    repeat (4) @(negedge clk);
    chk(16'(tq.size()), 16'h0001);
    chk(tq[0], 16'h003C);
    chk(16'(rd_n), 16'h0001);
    // Sleep-type strobes act only once select is high again
    foreach (dq[k]) begin
      acc(dq[k], 1'b1, 1'b1, stat(1'b0));
      repeat (10) @(negedge clk);
      chk(sq.pop_front(), {8'h00, 2'b01, dq[k][5:0]});
    end
    // Reset strobe then a header in the same frame; host must wait for ready
    acc(8'h30, 1'b1, 1'b0, stat(1'b0));
    acc(8'h3D, 1'b1, 1'b1, stat(1'b0));
    repeat (10) @(negedge clk);
    chk(16'(sq.size()), 16'h0002);
    chk(sq[0], 16'h0030);
    chk(sq[1], 16'h003D);
    // Reset strobe must have put the register written at 0x05 back to default
    acc(8'h85, 1'b1, 1'b0, stat(1'b1));
    acc(8'h00, 1'b0, 1'b1, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
